// file: stat_pkg.sv
// Purpose: shared constants and carriers for the statistics event select
// Assumes: one clock, register port with one-cycle read latency
// Notes: register offsets are local to this block
package stat_pkg;

  // register offsets (word index on the plain register port)
  localparam logic [3:0] ADDR_CTRL = 4'h0;   // select fields
  localparam logic [3:0] ADDR_COUNT = 4'h1;  // accumulated count
  localparam logic [3:0] ADDR_EVENTS = 4'h2; // live event flags

  // field positions inside the control word
  localparam int PRIO_LSB = 0;   // priority mask bits 3:0
  localparam int DIR_BIT = 7;    // direction select
  localparam int TYPE_LSB = 8;   // event type bits 10:8

  // values after reset
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;

  // event type encodings
  typedef enum logic [2:0] {
    EV_UNI_REQ = 3'b000,   // unicast requests only
    EV_UNI_ALL = 3'b001,   // every unicast packet not retried
    EV_RETRY_CS = 3'b010,  // retry control symbols
    EV_OTHER_CS = 3'b011,  // non-retry control symbols
    EV_UNI_DATA = 3'b100,  // per 32-bit unicast word
    EV_RSVD5 = 3'b101,     // no event counted
    EV_RSVD6 = 3'b110,     // no event counted
    EV_MC_CS = 3'b111      // multicast control symbols
  } event_type_e;

  // one side's event strobes for one cycle
  typedef struct packed {
    logic pkt_valid;     // packet seen this cycle
    logic pkt_request;   // packet is a request
    logic pkt_response;  // packet is a response
    logic pkt_maint;     // packet is maintenance
    logic pkt_retried;   // packet was retried
    logic pkt_accepted;  // packet was accepted
    logic pkt_unicast;   // packet is unicast
    logic [1:0] pkt_prio; // packet priority
    logic data_word;     // one 32-bit data word of the packet
    logic cs_valid;      // control symbol seen
    logic cs_retry;      // control symbol is retry
    logic cs_multicast;  // control symbol is multicast
  } side_events_s;

  // decoded control fields
  typedef struct packed {
    event_type_e event_type;
    logic direction;
    logic [3:0] prio_mask;
  } stat_ctrl_s;

endpackage

// file: event_match.sv
// Purpose: decides whether one side's events count this cycle
// Assumes: event strobes are synchronous to mclk
// Notes: purely combinational, registered by the caller
module event_match
  import stat_pkg::*;
(
  input wire stat_ctrl_s ctrl,
  input wire side_events_s ev,
  output logic hit
);

  logic prio_ok; // priority of the packet is enabled
  logic uni_ok;  // unicast packet, not retried

  // mask lookup; an all-zero mask never matches
  always_comb begin
    prio_ok = ctrl.prio_mask[ev.pkt_prio];
    uni_ok = ev.pkt_valid & ev.pkt_unicast & ~ev.pkt_retried;
  end

  // event type decode
  always_comb begin
    case (ctrl.event_type)
      EV_UNI_REQ: begin
        // requests only, no responses or maintenance of any hop count
        hit = uni_ok & prio_ok & ev.pkt_request & ~ev.pkt_response
            & ~ev.pkt_maint;
      end
      EV_UNI_ALL: begin
        hit = uni_ok & prio_ok;
      end
      EV_RETRY_CS: begin
        hit = ev.cs_valid & ev.cs_retry & (|ctrl.prio_mask);
      end
      EV_OTHER_CS: begin
        hit = ev.cs_valid & ~ev.cs_retry & (|ctrl.prio_mask);
      end
      EV_UNI_DATA: begin
        // words of retried packets never count
        hit = ev.data_word & ev.pkt_unicast & ev.pkt_accepted
            & ~ev.pkt_retried & prio_ok;
      end
      EV_MC_CS: begin
        hit = ev.cs_valid & ev.cs_multicast & (|ctrl.prio_mask);
      end
      default: begin
        hit = 1'b0; // unused encodings count nothing
      end
    endcase
  end

endmodule

// file: perf_stat_event_select.sv
// Purpose: event selection and accumulation for statistics counter 3
// Assumes: inputs synchronous to mclk; one-cycle read latency
// Notes: counter wraps at 32 bits; writes to count clear it to the value, plus one on a same-cycle hit
module perf_stat_event_select
  import stat_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire side_events_s rx_events,
  input wire side_events_s tx_events,
  output logic count_pulse
);

  stat_ctrl_s ctrl_q;   // software selection
  logic [31:0] count_q; // accumulated count
  logic [31:0] count_d;
  side_events_s sel_ev; // events of the chosen direction
  logic hit;            // selected event present this cycle
  logic [31:0] rdata_d;
  logic ctrl_wr;
  logic count_wr;

  assign ctrl_wr = reg_write & (reg_addr == ADDR_CTRL);
  assign count_wr = reg_write & (reg_addr == ADDR_COUNT);

  // direction steering happens before matching so both paths share
  // one decoder; the cost is one mux of the event bundle
  always_comb begin
    sel_ev = ctrl_q.direction ? tx_events : rx_events;
  end

  event_match u_match (
    .ctrl(ctrl_q),
    .ev(sel_ev),
    .hit(hit)
  );

  // control register, all fields clear after reset
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      // the struct packs type, direction and mask into eight bits
      ctrl_q <= stat_ctrl_s'(CTRL_RESET[7:0]);
    end else if (clk_en && ctrl_wr) begin
      ctrl_q.prio_mask <= reg_wdata[PRIO_LSB+3:PRIO_LSB];
      ctrl_q.direction <= reg_wdata[DIR_BIT];
      ctrl_q.event_type <= event_type_e'(reg_wdata[TYPE_LSB+2:TYPE_LSB]);
    end
  end

  // counter next value; a same-cycle hit adds onto a software write
  // so the event is not lost
  always_comb begin
    count_d = count_wr ? reg_wdata : count_q;
    if (hit) begin
      count_d = count_d + 32'h0000_0001;
    end
  end

  // accumulated count
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count_q <= COUNT_RESET;
    end else if (clk_en) begin
      count_q <= count_d;
    end
  end

  // registered hit pulse for observers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count_pulse <= 1'b0;
    end else if (clk_en) begin
      count_pulse <= hit;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (reg_addr)
      ADDR_CTRL: begin
        rdata_d[PRIO_LSB+3:PRIO_LSB] = ctrl_q.prio_mask;
        rdata_d[DIR_BIT] = ctrl_q.direction;
        rdata_d[TYPE_LSB+2:TYPE_LSB] = ctrl_q.event_type;
      end
      ADDR_COUNT: begin
        rdata_d = count_q;
      end
      ADDR_EVENTS: begin
        rdata_d[0] = hit;
        rdata_d[1] = ctrl_q.direction;
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      reg_rdata <= reg_read ? rdata_d : 32'h0000_0000;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  AST_DISABLED: assert property (
    clk_en && ctrl_q.prio_mask == 4'h0 && !count_wr
    |=> count_q == $past(count_q))
    else $error("counter moved with all priorities off");
  AST_RETRY_NO_COUNT: assert property (
    clk_en && sel_ev.pkt_retried && !sel_ev.cs_valid |-> !hit)
    else $error("retried packet counted");
  AST_REQ_ONLY: assert property (
    ctrl_q.event_type == EV_UNI_REQ && hit
    |-> sel_ev.pkt_request && !sel_ev.pkt_maint && !sel_ev.pkt_response)
    else $error("non-request counted in type 000");
  AST_UNI_ALL: assert property (
    ctrl_q.event_type == EV_UNI_ALL && sel_ev.pkt_valid
    && sel_ev.pkt_unicast && !sel_ev.pkt_retried
    && ctrl_q.prio_mask == 4'hF |-> hit)
    else $error("unicast packet missed in type 001");
  AST_RETRY_CS: assert property (
    ctrl_q.event_type == EV_RETRY_CS && hit |-> sel_ev.cs_retry)
    else $error("non-retry symbol counted in type 010");
  AST_OTHER_CS: assert property (
    ctrl_q.event_type == EV_OTHER_CS && hit |-> !sel_ev.cs_retry)
    else $error("retry symbol counted in type 011");
  AST_DATA: assert property (
    ctrl_q.event_type == EV_UNI_DATA && hit
    |-> sel_ev.pkt_accepted && sel_ev.data_word)
    else $error("unaccepted data counted");
  AST_MC: assert property (
    ctrl_q.event_type == EV_MC_CS && hit |-> sel_ev.cs_multicast)
    else $error("non-multicast symbol counted");
  AST_INC: assert property (
    clk_en && hit && !count_wr |=> count_q == $past(count_q) + 32'h1)
    else $error("count did not step by one");
  AST_READBACK: assert property (
    clk_en && reg_read && reg_addr == ADDR_CTRL
    |=> reg_rdata[DIR_BIT] == $past(ctrl_q.direction))
    else $error("control readback wrong");
  AST_FREEZE: assert property (
    !clk_en |=> count_q == $past(count_q) && ctrl_q == $past(ctrl_q))
    else $error("state moved while clock enable low");
  AST_RDATA_IDLE: assert property (
    clk_en && !reg_read |=> reg_rdata == 32'h0000_0000)
    else $error("read data stood outside its cycle");

  COV_TX: cover property (ctrl_q.direction && hit);
  COV_DATA: cover property (ctrl_q.event_type == EV_UNI_DATA && hit);
  COV_ALLPRIO: cover property (ctrl_q.prio_mask == 4'hF && hit);
  COV_FROZEN: cover property (!clk_en && hit);

endmodule

// file: stat_event_src.sv
// Purpose: far-side model that presents one side's event strobes
// Assumes: bench drives ev_in, to_tx and fire by NBA at rising mclk
// Notes: idle sides show scrambled qualifiers so stale fields cannot count
module stat_event_src
  import stat_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire side_events_s ev_in,
  input wire logic to_tx,
  input wire logic fire,
  output side_events_s rx_events,
  output side_events_s tx_events
);
  timeunit 1ns;
  timeprecision 1ps;
  side_events_s idle_ev; // qualifiers inverted, strobes low

  // strobes drop between events; qualifiers are never a clean zero
  always_comb begin
    idle_ev = ~ev_in;
    idle_ev.pkt_valid = 1'b0;
    idle_ev.data_word = 1'b0;
    idle_ev.cs_valid = 1'b0;
  end

  // only the chosen side carries the event, held for one cycle
  assign rx_events = (fire && !to_tx && resetn) ? ev_in : idle_ev;
  assign tx_events = (fire && to_tx && resetn) ? ev_in : idle_ev;
endmodule

// file: perf_stat_event_select_tb.sv
// Purpose: self-checking bench for the counter 3 event selection
// Assumes: register port with one-cycle read data, clk_en high except in the freeze case
// Notes: each case clears the count, fires one event, reads it back
module perf_stat_event_select_tb;
  import stat_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // event words: v rq rs mt rt ac uc p1 p0 dw cv cr cm
  localparam logic [12:0] REQ0 = 13'h18C0; // accepted unicast request
  localparam logic [12:0] REQ1 = 13'h18D0; // same at priority 1
  localparam logic [12:0] REQ3 = 13'h18F0; // same at priority 3
  localparam logic [12:0] RSP = 13'h14C0;  // unicast response
  localparam logic [12:0] MNT = 13'h12C0;  // maintenance packet
  localparam logic [12:0] RTY = 13'h19C0;  // retried request
  localparam logic [12:0] DW = 13'h10C8;   // accepted data word
  localparam logic [12:0] DWN = 13'h1048;  // data word, not accepted
  localparam logic [12:0] CSR = 13'h0006;  // retry control symbol
  localparam logic [12:0] CSN = 13'h0004;  // other control symbol
  localparam logic [12:0] CSM = 13'h0005;  // multicast control symbol
  logic mclk = 1'b0, resetn = 1'b0, clk_en = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_q;
  logic reg_write = 1'b0, reg_read = 1'b0, count_pulse;
  logic to_tx = 1'b0, fire = 1'b0;
  side_events_s ev_in = '0, rx_events, tx_events;
  int n_fail = 0, tests_run = 0, cyc = 0, n_case = 0;

  perf_stat_event_select u_perf_stat_event_select (.mclk(mclk),
    .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .rx_events(rx_events), .tx_events(tx_events),
    .count_pulse(count_pulse));
  stat_event_src u_stat_event_src (.mclk(mclk), .resetn(resetn),
    .ev_in(ev_in), .to_tx(to_tx), .fire(fire), .rx_events(rx_events),
    .tx_events(tx_events));

  // 200 MHz clock
  initial begin
    forever #2.5 mclk = ~mclk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // a hung bus would otherwise run forever
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // configure, clear count, fire one event, check pulse and count
  task automatic chk(input event_type_e t, input logic dir,
      input logic [3:0] mask, input logic tx, input logic [12:0] ev,
      input logic exp);
    logic [31:0] d;
    wr(ADDR_CTRL, {21'h0, t, dir, 3'h0, mask});
    wr(ADDR_COUNT, 32'h0);
    @(posedge mclk);
    ev_in <= side_events_s'(ev);
    to_tx <= tx;
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    #1 cmp({31'h0, count_pulse}, {31'h0, exp});
    rd(ADDR_COUNT, d);
    cmp(d, {31'h0, exp});
    n_case++;
    $display("case %0d done", n_case);
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    rd(ADDR_CTRL, rd_q);
    cmp(rd_q, 32'h0);
    rd(ADDR_COUNT, rd_q);
    cmp(rd_q, 32'h0);
    wr(ADDR_CTRL, 32'h0000_0783);
    rd(ADDR_CTRL, rd_q);
    cmp(rd_q, 32'h0000_0783);
    rd(ADDR_EVENTS, rd_q);
    cmp(rd_q, 32'h0000_0002);
    rd(4'hF, rd_q);
    cmp(rd_q, 32'h0);
    chk(EV_UNI_REQ, 1'b0, 4'hF, 1'b0, REQ0, 1'b1);
    chk(EV_UNI_REQ, 1'b0, 4'hF, 1'b0, RSP, 1'b0);
    chk(EV_UNI_REQ, 1'b0, 4'hF, 1'b0, MNT, 1'b0);
    chk(EV_UNI_ALL, 1'b0, 4'hF, 1'b0, RSP, 1'b1);
    chk(EV_UNI_ALL, 1'b0, 4'hF, 1'b0, MNT, 1'b1);
    chk(EV_UNI_ALL, 1'b0, 4'hF, 1'b0, RTY, 1'b0);
    chk(EV_RETRY_CS, 1'b0, 4'hF, 1'b0, CSR, 1'b1);
    chk(EV_RETRY_CS, 1'b0, 4'hF, 1'b0, CSN, 1'b0);
    chk(EV_OTHER_CS, 1'b0, 4'hF, 1'b0, CSN, 1'b1);
    chk(EV_OTHER_CS, 1'b0, 4'hF, 1'b0, CSR, 1'b0);
    chk(EV_UNI_DATA, 1'b0, 4'hF, 1'b0, DW, 1'b1);
    chk(EV_UNI_DATA, 1'b0, 4'hF, 1'b0, DWN, 1'b0);
    chk(EV_MC_CS, 1'b0, 4'hF, 1'b0, CSM, 1'b1);
    chk(EV_RSVD5, 1'b0, 4'hF, 1'b0, REQ0, 1'b0);
    chk(EV_UNI_ALL, 1'b0, 4'h1, 1'b0, REQ0, 1'b1);
    chk(EV_UNI_ALL, 1'b0, 4'h1, 1'b0, REQ1, 1'b0);
    chk(EV_UNI_ALL, 1'b0, 4'h0, 1'b0, REQ0, 1'b0);
    chk(EV_UNI_ALL, 1'b0, 4'hF, 1'b0, REQ3, 1'b1);
    chk(EV_UNI_ALL, 1'b1, 4'hF, 1'b0, REQ0, 1'b0);
    chk(EV_UNI_ALL, 1'b1, 4'hF, 1'b1, REQ0, 1'b1);
    chk(EV_UNI_ALL, 1'b0, 4'hF, 1'b1, REQ0, 1'b0);
    // clock enable low: an event in that cycle must not count
    wr(ADDR_CTRL, 32'h0000_010F);
    wr(ADDR_COUNT, 32'h0);
    @(posedge mclk);
    clk_en <= 1'b0;
    ev_in <= side_events_s'(REQ0);
    to_tx <= 1'b0;
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    clk_en <= 1'b1;
    rd(ADDR_COUNT, rd_q);
    cmp(rd_q, 32'h0);
    $display("case freeze done");
    complete_run();
  end
endmodule
